// ---- rtl/bbt_pkg.sv ----
// Shared constants, enumerations and carrier structs of the break and
// branch trace unit.
// Assumes the core presents one bus observation per mclk cycle.
package bbt_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	// Number of break channels.
	localparam int NUM_CH = 3;
	// Internal trace depth in branch records.
	localparam int TBUF_DEPTH = 8;
	// Address bits kept by the internal trace.
	localparam int TADDR_W = 28;
	// Width of the occurrence counter of channel 1.
	localparam int CNT_W = 12;

	// ------------------------------------------------------------------
	// Channel capabilities
	// ------------------------------------------------------------------
	// Bit positions of the condition kinds in a capability mask.
	localparam int CAP_ADDR = 0;
	localparam int CAP_DATA = 1;
	localparam int CAP_ADDRESS_SPACE_ID = 2;
	localparam int CAP_BS = 3;
	localparam int CAP_CNT = 4;
	localparam int CAP_IO = 5;
	localparam int CAP_TLB = 6;
	localparam int CAP_W = 7;
	// Capability mask per channel, index 0 is channel 1.
	localparam logic [NUM_CH-1:0][CAP_W-1:0] CH_CAP =
		{7'h60, 7'h0d, 7'h1f};

	// ------------------------------------------------------------------
	// Trace port record format
	// ------------------------------------------------------------------
	// Upper bits that must agree with the previous source for each form.
	localparam int KEEP_5 = 28;
	localparam int KEEP_9 = 24;
	localparam int KEEP_17 = 16;
	// Header nibble naming the length of the source field.
	localparam logic [3:0] HDR_5 = 4'h0;
	localparam logic [3:0] HDR_9 = 4'h1;
	localparam logic [3:0] HDR_17 = 4'h2;
	localparam logic [3:0] HDR_32 = 4'h3;
	// Source field length in nibbles for each form.
	localparam logic [4:0] NIB_5 = 5'h02;
	localparam logic [4:0] NIB_9 = 5'h03;
	localparam logic [4:0] NIB_17 = 5'h05;
	localparam logic [4:0] NIB_32 = 5'h08;
	// Header, destination and instruction word nibbles.
	localparam logic [4:0] NIB_FIX = 5'h0d;
	// Width of the outgoing shift image.
	localparam int REC_W = 84;
	// Reset value of the remembered source address.
	localparam logic [31:0] LAST_SRC_RST = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	// Access size seen on the bus.
	typedef enum logic [2:0]
	{
		BBT_SZ_BYTE,
		BBT_SZ_WORD,
		BBT_SZ_LONG,
		BBT_SZ_XBUS,
		BBT_SZ_YBUS
	} bbt_size_t;

	// One cycle of observed core activity.
	typedef struct packed
	{
		logic [31:0] addr;
		logic addr_valid;
		logic [31:0] pc;
		logic pc_valid;
		logic [31:0] data;
		logic data_valid;
		bbt_size_t size;
		logic [15:0] xy_addr;
		logic [15:0] xy_data;
		logic xy_valid;
		logic [7:0] address_space_id;
		logic rd_b;
		logic read_write_dir;
		logic [2:0] bus_state;
		logic io_access;
		logic tlb_entry_load_instr;
	} bbt_bus_t;

	// Configuration of one break channel.
	typedef struct packed
	{
		logic addr_en;
		logic [31:0] addr_val;
		logic data_en;
		logic [31:0] data_val;
		bbt_size_t size_sel;
		logic xy_en;
		logic [15:0] xy_addr;
		logic [15:0] xy_data;
		logic address_space_id_en;
		logic [7:0] address_space_id_val;
		logic rw_en;
		logic rw_use_dir;
		logic rw_lvl;
		logic bs_en;
		logic [2:0] bs_val;
		logic cnt_en;
		logic [CNT_W-1:0] cnt_val;
		logic io_en;
		logic tlb_en;
	} bbt_chcfg_t;

	// One branch as offered by the core.
	typedef struct packed
	{
		logic [31:0] src;
		logic [31:0] dst;
		logic [15:0] instr;
	} bbt_rec_t;

	// One internal trace entry.
	typedef struct packed
	{
		logic [TADDR_W-1:0] src;
		logic [TADDR_W-1:0] dst;
	} bbt_tent_t;

endpackage : bbt_pkg

// ---- rtl/bbt_trace_port.sv ----
// Serialiser of branch records onto the external trace port.
// Assumes the probe clock is slow against mclk and the probe samples
// data on the rising edge of trace_port_clock.
`timescale 1ns/1ps
module bbt_trace_port
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic trace_port_clock,
	input wire logic rt_mode,
	input wire logic rec_valid,
	input wire bbt_pkg::bbt_rec_t rec,
	output logic rec_ready,
	output logic busy,
	output logic [3:0] trace_data,
	output logic trace_sync_b
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	// All state of the serialiser in one record.
	typedef struct packed
	{
		logic ck_s1;
		logic ck_s2;
		logic ck_prev;
		logic [bbt_pkg::REC_W-1:0] img;
		logic [4:0] left;
		logic hdr_next;
		logic [31:0] last_src;
		logic [3:0] data;
		logic sync_b;
	} bbt_tp_st_t;

	bbt_tp_st_t st_r;
	bbt_tp_st_t st_nxt;
	// Rising edge of the synchronised probe clock.
	logic ck_rise;
	// A record is loaded in this cycle.
	logic take;
	// Header and nibble count of the offered source.
	logic [3:0] hdr;
	logic [4:0] nib;

	// A new record may replace a running one only in realtime mode.
	assign rec_ready = !busy || rt_mode; // RULE_16
	assign busy = st_r.left != 5'h00;
	assign take = rec_valid && rec_ready;
	assign ck_rise = st_r.ck_s2 && !st_r.ck_prev;
	assign trace_data = st_r.data;
	assign trace_sync_b = st_r.sync_b;

	// Pick the shortest source form that the probe can rebuild.
	always_comb
	begin
		if (rec.src[31:32-bbt_pkg::KEEP_5] ==
			st_r.last_src[31:32-bbt_pkg::KEEP_5])
		begin
			hdr = bbt_pkg::HDR_5; // RULE_20
			nib = bbt_pkg::NIB_5;
		end
		else if (rec.src[31:32-bbt_pkg::KEEP_9] ==
			st_r.last_src[31:32-bbt_pkg::KEEP_9])
		begin
			hdr = bbt_pkg::HDR_9; // RULE_20
			nib = bbt_pkg::NIB_9;
		end
		else if (rec.src[31:32-bbt_pkg::KEEP_17] ==
			st_r.last_src[31:32-bbt_pkg::KEEP_17])
		begin
			hdr = bbt_pkg::HDR_17; // RULE_20
			nib = bbt_pkg::NIB_17;
		end
		else
		begin
			hdr = bbt_pkg::HDR_32;
			nib = bbt_pkg::NIB_32;
		end
	end

	// Next state: synchronise the clock, load or shift the image.
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.ck_s1 = trace_port_clock;
		st_nxt.ck_s2 = st_r.ck_s1;
		st_nxt.ck_prev = st_r.ck_s2;
		if (take)
		begin
			// Source goes last so its length can vary. RULE_15 RULE_23
			st_nxt.img = {hdr, rec.dst, rec.instr,
				32'(rec.src << (6'd32 - {nib[3:0], 2'b00}))};
			st_nxt.left = bbt_pkg::NIB_FIX + nib;
			st_nxt.hdr_next = 1'b1;
			st_nxt.last_src = rec.src;
		end
		else if (ck_rise && busy)
		begin
			st_nxt.data = st_r.img[bbt_pkg::REC_W-1 -: 4];
			st_nxt.sync_b = !st_r.hdr_next; // RULE_23
			st_nxt.img = {st_r.img[bbt_pkg::REC_W-5:0], 4'h0};
			st_nxt.left = st_r.left - 5'h01;
			st_nxt.hdr_next = 1'b0;
		end
		else if (ck_rise)
		begin
			// Idle lines between records.
			st_nxt.data = 4'h0;
			st_nxt.sync_b = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= '{ck_s1: 1'b0, ck_s2: 1'b0, ck_prev: 1'b0,
				img: '0, left: 5'h00, hdr_next: 1'b0,
				last_src: bbt_pkg::LAST_SRC_RST, data: 4'h0,
				sync_b: 1'b1};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Realtime loads always start a fresh record.
	chk_rt_restart: assert property (@(posedge mclk) disable iff (!rst_b)
		(rec_valid && rt_mode) |=> (st_r.hdr_next && busy)) // RULE_16
		else $error("realtime record not restarted");
	// A near source is sent in its shortest form.
	chk_short_src: assert property (@(posedge mclk) disable iff (!rst_b)
		(take && rec.src[31:4] == st_r.last_src[31:4])
		|=> st_r.left == 5'h0f) // RULE_20
		else $error("short source form not used");
	// Sync strobe stays high between records.
	chk_idle_sync: assert property (@(posedge mclk) disable iff (!rst_b)
		(!busy && !$past(busy)) |-> trace_sync_b) // RULE_23
		else $error("sync strobe low while idle");

endmodule : bbt_trace_port

// ---- rtl/bbt_top.sv ----
// Break condition channels and branch trace of the core debug support.
// Assumes the core holds branch_valid steady while cpu_stall is high and
// that config inputs change only while the core is stopped.
//
// Summary of operation
// RULE_01 - Break on address bus or PC match.
// RULE_02 - Break on data match with size qualifier.
// RULE_03 - Break on X/Y address or data match.
// RULE_04 - Break on address space identifier match.
// RULE_05 - Break on read strobe or direction level.
// RULE_06 - Break on matching bus cycle state.
// RULE_07 - Break on any internal I/O access.
// RULE_08 - Break on TLB entry load instruction.
// RULE_09 - Count matches, break at programmed count.
// RULE_10 - Three channels with fixed condition sets.
// RULE_11 - Internal trace records branches without stalling; capture waits on port_ready, so non-realtime mode stalls.
// RULE_12 - Internal buffer keeps latest eight branches.
// RULE_13 - Internal entries keep low 28 address bits.
// RULE_14 - Resume writes stop-to-resume entry.
// RULE_15 - Port sends source, destination, instruction word.
// RULE_16 - Realtime mode abandons record for new one.
// RULE_17 - Non-realtime mode stalls CPU until sent.
// RULE_18 - Continue mode overwrites oldest when full.
// RULE_19 - Stop mode stops capture when full.
// RULE_20 - Source sent relative to previous source.
// RULE_21 - Probe rebuilds full addresses from parts.
// RULE_22 - Probe clock between quarter and full CPU; bbt_probe runs it at one eighth of mclk.
// RULE_23 - Nibble framing delimited by sync strobe.
// RULE_24 - Channels merged into one break, source kept.
`timescale 1ns/1ps
module bbt_top
#(
	parameter int DEPTH = bbt_pkg::TBUF_DEPTH
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire bbt_pkg::bbt_bus_t bus,
	input wire bbt_pkg::bbt_chcfg_t [bbt_pkg::NUM_CH-1:0] ch_cfg,
	input wire logic break_src_clr_1,
	input wire logic break_src_clr_2,
	input wire logic break_src_clr_3,
	output logic break_req,
	output logic [bbt_pkg::NUM_CH-1:0] break_src,
	input wire logic branch_valid,
	input wire bbt_pkg::bbt_rec_t branch,
	input wire logic exec_stop,
	input wire logic [31:0] stop_pc,
	input wire logic exec_resume,
	input wire logic [31:0] resume_pc,
	input wire logic trace_realtime,
	input wire logic trace_stop_mode,
	input wire logic trace_clear,
	input wire logic [$clog2(DEPTH)-1:0] trace_rd_idx,
	output bbt_pkg::bbt_tent_t trace_rd,
	output logic [$clog2(DEPTH):0] trace_count,
	output logic trace_full,
	output logic cpu_stall,
	input wire logic trace_port_clock,
	output logic [3:0] trace_data,
	output logic trace_sync_b
);

	// ------------------------------------------------------------------
	// Local sizes and state
	// ------------------------------------------------------------------
	// Pointer and count widths of the internal buffer.
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

	// All state of the unit in one record.
	typedef struct packed
	{
		logic [bbt_pkg::CNT_W-1:0] cnt;
		logic brk;
		logic [bbt_pkg::NUM_CH-1:0] src;
		bbt_pkg::bbt_tent_t [DEPTH-1:0] tbuf;
		logic [PW-1:0] wptr;
		logic [PW:0] tcount;
		logic [31:0] last_stop;
		bbt_pkg::bbt_tent_t rd;
	} bbt_top_st_t;

	bbt_top_st_t st_r;
	bbt_top_st_t st_nxt;

	// Raw condition hit per channel, before the occurrence count.
	logic [bbt_pkg::NUM_CH-1:0] ch_hit;
	// Channel raises a break in this cycle.
	logic [bbt_pkg::NUM_CH-1:0] ch_fire;
	// Clear strobes gathered into one vector.
	logic [bbt_pkg::NUM_CH-1:0] src_clr;
	// Channel 1 counting in effect.
	logic cnt_on;
	// Count reached on this hit.
	logic cnt_done;
	// Capture blocked because stop mode found the buffer full.
	logic cap_block;
	// Trace port can take the offered branch.
	logic port_ready;
	// Serialiser has a record in flight.
	logic port_busy;
	// Branch handed over in this cycle.
	logic br_take;

	assign src_clr = {break_src_clr_3, break_src_clr_2, break_src_clr_1};

	// ------------------------------------------------------------------
	// Break channels
	// ------------------------------------------------------------------
	// Each channel checks only the kinds its capability mask allows; a
	// kind outside the mask is ignored even if its enable is set.
	genvar gi;
	generate
		for (gi = 0; gi < bbt_pkg::NUM_CH; gi++)
		begin : g_ch
			// Enabled kinds after capability masking.
			logic [bbt_pkg::CAP_W-1:0] en;
			// Per kind match result.
			logic [bbt_pkg::CAP_W-1:0] ok;
			// Data value compared at the selected access width.
			logic [31:0] dmask;
			logic data_ok;
			logic xy_ok;
			logic rw_ok;

			assign en = {ch_cfg[gi].tlb_en, ch_cfg[gi].io_en,
				ch_cfg[gi].cnt_en,
				ch_cfg[gi].bs_en || ch_cfg[gi].rw_en,
				ch_cfg[gi].address_space_id_en,
				ch_cfg[gi].data_en || ch_cfg[gi].xy_en,
				ch_cfg[gi].addr_en} & bbt_pkg::CH_CAP[gi]; // RULE_10

			// Byte and word accesses compare only their low lanes.
			always_comb
			begin
				case (ch_cfg[gi].size_sel)
					bbt_pkg::BBT_SZ_BYTE: dmask = 32'h0000_00ff;
					bbt_pkg::BBT_SZ_WORD: dmask = 32'h0000_ffff;
					bbt_pkg::BBT_SZ_XBUS: dmask = 32'h0000_ffff;
					bbt_pkg::BBT_SZ_YBUS: dmask = 32'h0000_ffff;
					default: dmask = 32'hffff_ffff;
				endcase
			end

			assign data_ok = !ch_cfg[gi].data_en || (bus.data_valid &&
				bus.size == ch_cfg[gi].size_sel &&
				((bus.data ^ ch_cfg[gi].data_val) & dmask) ==
				32'h0000_0000); // RULE_02
			assign xy_ok = !ch_cfg[gi].xy_en || (bus.xy_valid &&
				(bus.xy_addr == ch_cfg[gi].xy_addr ||
				bus.xy_data == ch_cfg[gi].xy_data)); // RULE_03
			assign rw_ok = !ch_cfg[gi].rw_en || (bus.addr_valid &&
				(ch_cfg[gi].rw_use_dir ?
				bus.read_write_dir == ch_cfg[gi].rw_lvl :
				bus.rd_b == ch_cfg[gi].rw_lvl)); // RULE_05

			assign ok[bbt_pkg::CAP_ADDR] =
				(bus.addr_valid && bus.addr == ch_cfg[gi].addr_val) ||
				(bus.pc_valid && bus.pc == ch_cfg[gi].addr_val); // RULE_01
			assign ok[bbt_pkg::CAP_DATA] = data_ok && xy_ok;
			assign ok[bbt_pkg::CAP_ADDRESS_SPACE_ID] =
				bus.address_space_id == ch_cfg[gi].address_space_id_val; // RULE_04
			assign ok[bbt_pkg::CAP_BS] = rw_ok &&
				(!ch_cfg[gi].bs_en || (bus.addr_valid &&
				bus.bus_state == ch_cfg[gi].bs_val)); // RULE_06
			// Counting adds no condition of its own.
			assign ok[bbt_pkg::CAP_CNT] = 1'b1;
			assign ok[bbt_pkg::CAP_IO] = bus.io_access; // RULE_07
			assign ok[bbt_pkg::CAP_TLB] =
				bus.tlb_entry_load_instr; // RULE_08

			// All enabled kinds must hold; counting alone never hits.
			assign ch_hit[gi] = ((en & ~ok) == '0) &&
				((en & ~(bbt_pkg::CAP_W'(1) << bbt_pkg::CAP_CNT)) != '0);
		end
	endgenerate

	// Only channel 1 can count; a count of zero behaves as one.
	assign cnt_on = ch_cfg[0].cnt_en && bbt_pkg::CH_CAP[0][bbt_pkg::CAP_CNT];
	assign cnt_done = st_r.cnt + bbt_pkg::CNT_W'(1) >= ch_cfg[0].cnt_val;
	assign ch_fire[0] = ch_hit[0] && (!cnt_on || cnt_done); // RULE_09
	assign ch_fire[bbt_pkg::NUM_CH-1:1] = ch_hit[bbt_pkg::NUM_CH-1:1];

	// ------------------------------------------------------------------
	// Trace hand-over
	// ------------------------------------------------------------------
	// In stop mode a full buffer drops branches without stalling.
	assign trace_full = st_r.tcount == DEPTH_C;
	assign cap_block = trace_stop_mode && trace_full; // RULE_19
	assign br_take = branch_valid && !cap_block && port_ready;
	// Only non-realtime mode holds the core back. RULE_17
	assign cpu_stall = branch_valid && !cap_block && !trace_realtime &&
		!port_ready;

	bbt_trace_port u_port
	(
		.mclk(mclk),
		.rst_b(rst_b),
		.trace_port_clock(trace_port_clock),
		.rt_mode(trace_realtime),
		.rec_valid(branch_valid && !cap_block),
		.rec(branch),
		.rec_ready(port_ready),
		.busy(port_busy),
		.trace_data(trace_data),
		.trace_sync_b(trace_sync_b)
	);

	assign break_req = st_r.brk;
	assign break_src = st_r.src;
	assign trace_count = st_r.tcount;
	assign trace_rd = st_r.rd;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// Count, break merge and the internal trace buffer.
	always_comb
	begin
		st_nxt = st_r;
		// Occurrence counter restarts after every break it produces.
		if (cnt_on && ch_hit[0])
		begin
			st_nxt.cnt = cnt_done ? '0 : st_r.cnt + bbt_pkg::CNT_W'(1);
		end
		else if (!cnt_on)
		begin
			st_nxt.cnt = '0;
		end
		// One break to the core; a new fire beats a clear. RULE_24
		st_nxt.brk = |ch_fire;
		st_nxt.src = (st_r.src & ~src_clr) | ch_fire;
		if (exec_stop)
		begin
			st_nxt.last_stop = stop_pc;
		end
		// Resume entry takes the slot; a same-cycle branch is not recorded.
		if (trace_clear)
		begin
			st_nxt.wptr = '0;
			st_nxt.tcount = '0;
		end
		else if ((exec_resume || br_take) && !cap_block)
		begin
			if (exec_resume)
			begin
				st_nxt.tbuf[st_r.wptr] = '{
					src: st_r.last_stop[bbt_pkg::TADDR_W-1:0],
					dst: resume_pc[bbt_pkg::TADDR_W-1:0]}; // RULE_14
			end
			else
			begin
				st_nxt.tbuf[st_r.wptr] = '{
					src: branch.src[bbt_pkg::TADDR_W-1:0],
					dst: branch.dst[bbt_pkg::TADDR_W-1:0]}; // RULE_13
			end
			// Wrapping pointer drops the oldest entry. RULE_12 RULE_18
			st_nxt.wptr = (st_r.wptr == PW'(DEPTH - 1)) ? '0 :
				st_r.wptr + PW'(1);
			if (!trace_full)
			begin
				st_nxt.tcount = st_r.tcount + (PW+1)'(1);
			end
		end
		// Read index 0 is the newest entry; reads never stall. RULE_11
		st_nxt.rd = st_r.tbuf[PW'(st_r.wptr - PW'(1) - trace_rd_idx)];
	end

	// State register.
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	// Any firing channel reaches the core one cycle later.
	chk_break_merge: assert property (@(posedge mclk) disable iff (!rst_b)
		(|ch_fire) |=> (break_req && (break_src & $past(ch_fire)) ==
		$past(ch_fire))) // RULE_24
		else $error("break not merged or source not recorded");
	// A set channel 1 source flag holds until its clear.
	chk_src_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		(break_src[0] && !break_src_clr_1) |=> break_src[0]) // RULE_24
		else $error("break source flag lost");
	// Channel 3 fires on an internal I/O access alone.
	chk_io_break: assert property (@(posedge mclk) disable iff (!rst_b)
		(ch_cfg[2].io_en && !ch_cfg[2].tlb_en && bus.io_access)
		|-> ch_fire[2]) // RULE_07
		else $error("internal io access did not break");
	// Channel 3 fires on a TLB entry load alone.
	chk_tlb_break: assert property (@(posedge mclk) disable iff (!rst_b)
		(ch_cfg[2].tlb_en && !ch_cfg[2].io_en &&
		bus.tlb_entry_load_instr) |-> ch_fire[2]) // RULE_08
		else $error("tlb load did not break");
	// Channel 2 ignores data conditions.
	chk_ch2_nodata: assert property (@(posedge mclk) disable iff (!rst_b)
		(ch_cfg[1].addr_en && bus.pc_valid &&
		bus.pc == ch_cfg[1].addr_val && !ch_cfg[1].address_space_id_en &&
		!ch_cfg[1].bs_en && !ch_cfg[1].rw_en) |-> ch_fire[1]) // RULE_10
		else $error("channel 2 blocked by unsupported condition");
	// Counting hits stay silent until the count is reached.
	chk_count_wait: assert property (@(posedge mclk) disable iff (!rst_b)
		(cnt_on && ch_hit[0] && !cnt_done) |-> (!ch_fire[0] ##1
		st_r.cnt == $past(st_r.cnt) + bbt_pkg::CNT_W'(1))) // RULE_09
		else $error("count break fired early");
	// Stop mode freezes a full buffer.
	chk_stop_full: assert property (@(posedge mclk) disable iff (!rst_b)
		(cap_block && !trace_clear) |=> $stable(st_r.wptr)) // RULE_19
		else $error("capture continued in stop mode");
	// The buffer never claims more than its depth.
	chk_depth: assert property (@(posedge mclk) disable iff (!rst_b)
		trace_count <= DEPTH_C) // RULE_12
		else $error("trace count above depth");
	// Realtime mode hands every branch over at once, never stalling.
	chk_rt_nostall: assert property (@(posedge mclk) disable iff (!rst_b)
		(trace_realtime && branch_valid && !cap_block)
		|-> (br_take && !cpu_stall)) // RULE_16
		else $error("core stalled in realtime mode");
	// An idle port takes a non-realtime branch without a stall.
	chk_stall_end: assert property (@(posedge mclk) disable iff (!rst_b)
		(branch_valid && !cap_block && !trace_realtime && !port_busy)
		|-> (br_take && !cpu_stall)) // RULE_17
		else $error("stall with idle trace port");

endmodule : bbt_top

// ---- sim/bbt_probe.sv ----
// Emulator probe model: runs the trace clock, rebuilds branch records.
// Assumes the unit shifts one nibble per rising trace clock edge.
`timescale 1ns/1ps
module bbt_probe
(
	input wire logic run,
	output logic trace_port_clock,
	input wire logic [3:0] trace_data,
	input wire logic trace_sync_b,
	output logic got,
	output bbt_pkg::bbt_rec_t rec
);
	int nib [4] = '{bbt_pkg::NIB_5, bbt_pkg::NIB_9, bbt_pkg::NIB_17, 8};
	int kp [4] = '{bbt_pkg::KEEP_5, bbt_pkg::KEEP_9, bbt_pkg::KEEP_17, 0};
	logic [1:0] k = 2'h0; // Form of the record in progress.
	logic [4:0] n = 5'h00; // Nibbles still due.
	logic [79:0] sh = '0; // Collected nibbles.
	logic [79:0] f; // Collected nibbles including this edge.
	logic [31:0] m; // Low bits that the record carries.
	logic [31:0] src_r = bbt_pkg::LAST_SRC_RST; // Last rebuilt source.
	logic [31:0] s; // Rebuilt source of this record.
	// --------------------------------------------------------------
	// Clock stands still while no traffic is wanted.
	// --------------------------------------------------------------
	initial
	begin
		trace_port_clock = 1'b0;
		got = 1'b0;
		forever
		begin
			#200;
			// Kept well below mclk so every edge is seen.
			trace_port_clock = run ? ~trace_port_clock : 1'b0;
		end
	end
	// A header restarts the record, so an abandoned one is dropped.
	always @(posedge trace_port_clock)
	begin
		f = {sh[75:0], trace_data};
		got <= 1'b0;
		if (trace_sync_b === 1'b0)
		begin
			k <= trace_data[1:0];
			n <= 5'(12 + nib[trace_data[1:0]]);
		end
		else if (n != 5'h00)
		begin
			sh <= f;
			n <= n - 5'h01;
			if (n == 5'h01)
			begin
				m = 32'hffffffff >> kp[k];
				s = (src_r & ~m) | (f[31:0] & m);
				rec <= {s, 32'(f >> (nib[k] * 4 + 16)), 16'(f >> (nib[k] * 4))};
				src_r <= s;
				got <= 1'b1;
			end
		end
	end
endmodule : bbt_probe

// ---- sim/tb_top.sv ----
// Self-checking bench of the break and branch trace unit.
// Assumes bbt_probe stands on the trace port and makes its clock.
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst_b, clr1, clr2, clr3, bv, stp, rsm, rt, smode, tclr;
	logic run, breq, full, stall, tck, tsync_b, got;
	bbt_pkg::bbt_bus_t bus, b;
	bbt_pkg::bbt_chcfg_t [bbt_pkg::NUM_CH-1:0] cfg;
	bbt_pkg::bbt_rec_t branch, prec;
	bbt_pkg::bbt_rec_t br [9];
	bbt_pkg::bbt_tent_t trd;
	logic [31:0] spc, rpc, a;
	logic [31:0] msk [4] = '{32'hf, 32'hff, 32'hffff, 32'hffffffff};
	logic [2:0] idx, bsrc;
	logic [3:0] cnt, tdat;
	int miscompares, n_checks, stalls, cyc;
	logic [2:0] qb [$]; // Expected source flags per break pulse.
	bbt_pkg::bbt_rec_t qr [$]; // Expected records at the probe.
	bbt_top i_dut (.mclk(mclk), .rst_b(rst_b), .bus(bus), .ch_cfg(cfg),
		.break_src_clr_1(clr1), .break_src_clr_2(clr2),
		.break_src_clr_3(clr3), .break_req(breq), .break_src(bsrc),
		.branch_valid(bv), .branch(branch), .exec_stop(stp), .stop_pc(spc),
		.exec_resume(rsm), .resume_pc(rpc), .trace_realtime(rt),
		.trace_stop_mode(smode), .trace_clear(tclr), .trace_rd_idx(idx),
		.trace_rd(trd), .trace_count(cnt), .trace_full(full),
		.cpu_stall(stall), .trace_port_clock(tck), .trace_data(tdat),
		.trace_sync_b(tsync_b));
	bbt_probe i_probe (.run(run), .trace_port_clock(tck), .trace_data(tdat),
		.trace_sync_b(tsync_b), .got(got), .rec(prec));
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input logic [79:0] seen, input logic [79:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	// A hang ends the run as a failure.
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	// Each break pulse takes the oldest expected source set.
	always @(negedge mclk)
		if (breq === 1'b1)
			check(bsrc, qb.size() ? qb.pop_front() : 3'h0);
	always @(posedge got)
	begin
		#1;
		check(prec, qr.size() ? qr.pop_front() : '0);
	end
	task automatic pulse;
		@(negedge mclk) bus = b;
		@(negedge mclk) bus = '0;
	endtask : pulse
	task automatic clr_all;
		{clr1, clr2, clr3} = 3'h7;
		@(negedge mclk) {clr1, clr2, clr3} = 3'h0;
	endtask : clr_all
	// Called at a falling edge; holds the branch while stalled.
	task automatic branch_go(input bbt_pkg::bbt_rec_t r);
		logic s;
		branch = r;
		bv = 1'b1;
		do
		begin
			#20 s = stall;
			if (s === 1'b1)
				stalls++;
			@(negedge mclk);
		end while (s === 1'b1);
	endtask : branch_go
	task automatic rd(input logic [2:0] i, input bbt_pkg::bbt_tent_t e);
		idx = i;
		@(negedge mclk) check(trd, e);
	endtask : rd
	function automatic bbt_pkg::bbt_tent_t tent(bbt_pkg::bbt_rec_t r);
		return {r.src[27:0], r.dst[27:0]};
	endfunction : tent
	initial
	begin
		{clr1, clr2, clr3, bv, stp, rsm, rt, smode, tclr, run} = '0;
		{bus, b, cfg, branch, spc, rpc, idx} = '0;
		rst_b = 1'b0;
		a = $urandom(32'h34e8);
		repeat (3) @(posedge mclk);
		@(negedge mclk) rst_b = 1'b1;
		a = $urandom;
		cfg[0].addr_en = 1'b1;
		cfg[0].addr_val = a;
		b.addr = a;
		b.addr_valid = 1'b1;
		qb.push_back(3'h1);
		pulse();
		clr_all();
		b = '0;
		b.pc = a;
		b.pc_valid = 1'b1;
		qb.push_back(3'h1);
		pulse();
		clr_all();
		b = '0;
		b.addr = a ^ 32'h1;
		b.addr_valid = 1'b1;
		pulse();
		b.addr = a;
		cfg[0].cnt_en = 1'b1;
		cfg[0].cnt_val = 12'h003;
		qb.push_back(3'h1);
		repeat (3) pulse();
		clr_all();
		cfg = '0;
		cfg[1].data_en = 1'b1;
		cfg[1].data_val = a;
		b = '0;
		b.data = a;
		b.data_valid = 1'b1;
		b.size = bbt_pkg::BBT_SZ_LONG;
		pulse();
		cfg[1] = '0;
		cfg[1].address_space_id_en = 1'b1;
		cfg[1].address_space_id_val = a[7:0] | 8'h01;
		b.address_space_id = a[7:0] | 8'h01;
		qb.push_back(3'h2);
		pulse();
		clr_all();
		cfg[1] = '0;
		for (int k = 0; k < 2; k++)
		begin
			cfg[2].io_en = (k == 0);
			cfg[2].tlb_en = (k == 1);
			b = '0;
			b.io_access = (k == 0);
			b.tlb_entry_load_instr = (k == 1);
			qb.push_back(3'h4);
			pulse();
			clr_all();
		end
		repeat (3) @(negedge mclk);
		check(qb.size(), 0);
		$display("break tests done");
		run = 1'b1;
		a = bbt_pkg::LAST_SRC_RST;
		for (int k = 0; k < 4; k++)
		begin
			br[k] = {a ^ ($urandom & msk[k]), $urandom, 16'($urandom)};
			a = br[k].src;
			qr.push_back(br[k]);
			branch_go(br[k]);
		end
		bv = 1'b0;
		for (int w = 0; w < 4000 && qr.size() != 0; w++)
			@(negedge mclk);
		check(qr.size(), 0);
		check(stalls > 0, 1);
		// A record cut short in realtime mode gives way to the next.
		rt = 1'b1;
		br[4] = {a ^ ($urandom & msk[0]), $urandom, 16'($urandom)};
		br[5] = {br[4].src, $urandom, 16'($urandom)};
		qr.push_back(br[5]);
		branch_go(br[4]);
		branch_go(br[5]);
		bv = 1'b0;
		for (int w = 0; w < 4000 && qr.size() != 0; w++)
			@(negedge mclk);
		check(qr.size(), 0);
		run = 1'b0;
		$display("trace port test done");
		rt = 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			smode = m;
			stalls = 0;
			tclr = 1'b1;
			@(negedge mclk) tclr = 1'b0;
			for (int k = 0; k < 9; k++)
			begin
				br[k] = {$urandom, $urandom, 16'($urandom)};
				branch_go(br[k]);
			end
			bv = 1'b0;
			check(stalls, 0);
			check({full, cnt}, 5'h18);
			rd(3'h0, tent(br[m ? 7 : 8]));
			rd(3'h7, tent(br[m ? 0 : 1]));
		end
		smode = 1'b0;
		tclr = 1'b1;
		{spc, rpc} = {$urandom, $urandom};
		@(negedge mclk) {tclr, stp} = 2'h1;
		@(negedge mclk) {stp, rsm} = 2'h1;
		@(negedge mclk) rsm = 1'b0;
		@(negedge mclk) check(cnt, 4'h1);
		rd(3'h0, {spc[27:0], rpc[27:0]});
		$display("internal trace tests done");
		report_and_stop();
	end
endmodule : tb_top
